// ---- rtl/operand_address_and_flags.sv ----
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
module operand_address_and_flags #(
  parameter logic [7:0] ACCESS_SPLIT = datapath_pkg::ACCESS_SPLIT_DEF
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // decoder request
  input  wire logic                 req_valid,
  input  wire datapath_pkg::req_s   req,
  output logic                      req_ready,
  // results
  output logic                      done,
  output logic                      w_wr,
  output logic [7:0]                w_data,
  output logic [7:0]                status_flags,
  // data memory
  output datapath_pkg::mem_s        mem,
  input  wire logic [7:0]           mem_rdata,
  // register port
  input  wire logic [3:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata
);

  if (ACCESS_SPLIT == 8'h00) begin : g_bad_split
    $error("access split must be nonzero");
  end

  datapath_pkg::state_s st;
  datapath_pkg::state_s next_st;

  // locate an address among pointer operands, pointer bytes and status
  function automatic datapath_pkg::sfr_hit_s classify(input logic [11:0] a);
    datapath_pkg::sfr_hit_s h;
    logic [11:0]            bi;
    h  = '0;
    bi = '0;
    for (int i = 0; i < datapath_pkg::NUM_PTR; i++) begin
      bi = datapath_pkg::PTR_PLAIN_BASE - datapath_pkg::PTR_STRIDE * 12'(i);
      if (a <= bi && (bi - a) <= 12'(datapath_pkg::OFS_LOW)) begin
        h.idx      = 2'(i);
        h.ofs      = 3'(bi - a);
        h.virt     = (bi - a) <= 12'(datapath_pkg::OFS_OFFSET);
        h.ptr_byte = !h.virt;
      end
    end
    h.status = (a == datapath_pkg::STATUS_ADDR);
    return h;
  endfunction

  // byte view of an internal register
  function automatic logic [7:0] internal_read(input datapath_pkg::sfr_hit_s h,
                                               input datapath_pkg::state_s s);
    logic [7:0] v;
    v = 8'h00;
    if (h.status) begin
      v = {3'h0, s.flags};
    end else if (h.ptr_byte && h.ofs == datapath_pkg::OFS_HIGH) begin
      v = {4'h0, s.ptr[h.idx][11:8]};
    end else if (h.ptr_byte) begin
      v = s.ptr[h.idx][7:0];
    end
    return v;
  endfunction

  // store a byte into a pointer half
  function automatic logic [11:0] ptr_store(input logic [11:0] p, input logic high,
                                            input logic [7:0] d);
    logic [11:0] r;
    r = p;
    if (high) begin
      r[11:8] = d[3:0];
    end else begin
      r[7:0] = d;
    end
    return r;
  endfunction

  // address phase
  logic [11:0]            ea;
  logic [11:0]            tgt;
  logic [11:0]            p;
  datapath_pkg::sfr_hit_s eh;
  datapath_pkg::sfr_hit_s th;
  logic [11:0]            p_new;
  logic                   p_step;

  // execute phase
  logic [7:0] a_op;
  logic [7:0] x;
  logic [7:0] y;
  logic [7:0] yy;
  logic       sub;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] res;
  logic [4:0] f;
  logic       flag_op;
  logic       wr_file;

  always_comb begin
    next_st = st;
    ea      = '0;
    tgt     = '0;
    p       = '0;
    eh      = '0;
    th      = '0;
    p_new   = '0;
    p_step  = 1'b0;
    a_op    = '0;
    x       = '0;
    y       = '0;
    yy      = '0;
    sub     = 1'b0;
    sum     = '0;
    nib     = '0;
    res     = '0;
    f       = st.flags;
    flag_op = 1'b0;
    wr_file = 1'b0;

    next_st.mem.rd = 1'b0;
    next_st.mem.wr = 1'b0;
    next_st.done   = 1'b0;
    next_st.w_wr   = 1'b0;

    // register port
    if (reg_rd) begin
      if (reg_addr == datapath_pkg::REG_STATUS) begin
        next_st.rdata = {3'h0, st.flags};
      end else if (reg_addr <= datapath_pkg::REG_LAST) begin
        eh.ptr_byte   = 1'b1;
        eh.idx        = 2'((reg_addr - datapath_pkg::REG_PTR_BASE) >> 1);
        eh.ofs        = reg_addr[0] ? datapath_pkg::OFS_HIGH : datapath_pkg::OFS_LOW;
        next_st.rdata = internal_read(eh, st);
      end else begin
        next_st.rdata = 8'h00;
      end
    end
    if (reg_wr) begin
      if (reg_addr == datapath_pkg::REG_STATUS) begin
        next_st.flags = reg_wdata[4:0];
      end else if (reg_addr <= datapath_pkg::REG_LAST) begin
        next_st.ptr[2'((reg_addr - datapath_pkg::REG_PTR_BASE) >> 1)] =
          ptr_store(st.ptr[2'((reg_addr - datapath_pkg::REG_PTR_BASE) >> 1)],
                    reg_addr[0], reg_wdata);
      end
    end

    case (st.state)
      datapath_pkg::ST_IDLE: begin
        if (req_valid) begin
          // effective file address
          if (req.mode == datapath_pkg::MODE_FULL) begin
            ea = req.full_addr;
          end else if (req.access) begin
            ea = {req.bank, req.file_addr};
          end else if (req.file_addr < ACCESS_SPLIT) begin
            ea = {4'h0, req.file_addr};
          end else begin
            ea = {datapath_pkg::ACCESS_HIGH_BANK, req.file_addr};
          end
          eh  = classify(ea);
          tgt = ea;
          if (eh.virt && req.mode != datapath_pkg::MODE_NONE) begin
            // indirect: the pointer decides the target, plus the sign-extended W in offset mode
            p     = st.ptr[eh.idx];
            p_new = p;
            case (eh.ofs)
              datapath_pkg::OFS_INC_AFTER: begin
                tgt    = p;
                p_new  = p + 12'h001;
                p_step = 1'b1;
              end
              datapath_pkg::OFS_DEC_AFTER: begin
                tgt    = p;
                p_new  = p - 12'h001;
                p_step = 1'b1;
              end
              datapath_pkg::OFS_INC_BEFORE: begin
                tgt    = p + 12'h001;
                p_new  = tgt;
                p_step = 1'b1;
              end
              datapath_pkg::OFS_OFFSET: begin
                tgt    = p + {{4{req.w[7]}}, req.w};
                p_step = 1'b0;
              end
              default: begin
                tgt = p;
              end
            endcase
            th = classify(tgt);
            // a write landing in a pointer byte cancels the step
            if (th.ptr_byte && req.dest) begin
              p_step = 1'b0;
            end
            if (p_step) begin
              next_st.ptr[eh.idx] = p_new;
            end
            next_st.kill = th.virt;
          end else begin
            th           = eh;
            next_st.kill = eh.virt;
          end
          next_st.no_file  = (req.mode == datapath_pkg::MODE_NONE);
          next_st.internal = th.ptr_byte | th.status;
          next_st.hit      = th;
          next_st.op       = req.op;
          next_st.dest     = req.dest && req.mode != datapath_pkg::MODE_NONE;
          next_st.b        = req.use_lit ? req.lit : req.w;
          next_st.w        = req.w;
          next_st.mem.addr = tgt;
          next_st.mem.rd   = !next_st.no_file && !next_st.kill && !next_st.internal;
          next_st.state    = datapath_pkg::ST_EXEC;
        end
      end
      datapath_pkg::ST_EXEC: begin
        if (st.no_file) begin
          a_op = st.w;
        end else if (st.kill) begin
          a_op = 8'h00;
        end else if (st.internal) begin
          a_op = internal_read(st.hit, st);
        end else begin
          a_op = mem_rdata;
        end
        x = a_op;
        y = st.b;
        if (st.op == datapath_pkg::OP_SUBR) begin
          x = st.b;
          y = a_op;
        end
        sub = (st.op == datapath_pkg::OP_SUB) || (st.op == datapath_pkg::OP_SUBR);
        yy  = sub ? ~y : y;
        sum = {1'b0, x} + {1'b0, yy} + {8'h00, sub};
        nib = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + {4'h0, sub};
        flag_op = 1'b1;
        case (st.op)
          datapath_pkg::OP_ADD, datapath_pkg::OP_SUB, datapath_pkg::OP_SUBR: begin
            res = sum[7:0];
            f[datapath_pkg::STATUS_CARRY_BIT] = sum[8];
            f[datapath_pkg::STATUS_NIB_BIT]   = nib[4];
            f[datapath_pkg::STATUS_OVF_BIT]   = (x[7] == yy[7]) && (res[7] != x[7]);
          end
          datapath_pkg::OP_AND: res = x & y;
          datapath_pkg::OP_IOR: res = x | y;
          datapath_pkg::OP_XOR: res = x ^ y;
          datapath_pkg::OP_MOVF: res = a_op;
          datapath_pkg::OP_RRC: begin
            res = {st.flags[datapath_pkg::STATUS_CARRY_BIT], a_op[7:1]};
            f[datapath_pkg::STATUS_CARRY_BIT] = a_op[0];
            f[datapath_pkg::STATUS_NIB_BIT]   = a_op[4];
          end
          datapath_pkg::OP_RLC: begin
            res = {a_op[6:0], st.flags[datapath_pkg::STATUS_CARRY_BIT]};
            f[datapath_pkg::STATUS_CARRY_BIT] = a_op[7];
            f[datapath_pkg::STATUS_NIB_BIT]   = a_op[3];
          end
          default: begin
            res     = a_op;
            flag_op = 1'b0;
          end
        endcase
        f[datapath_pkg::STATUS_NEG_BIT]  = res[7];
        f[datapath_pkg::STATUS_ZERO_BIT] = (res == 8'h00);
        // write back
        wr_file = st.dest && !st.kill;
        if (st.dest) begin
          if (wr_file && !st.internal) begin
            next_st.mem.wr    = 1'b1;
            next_st.mem.wdata = res;
          end else if (wr_file && st.hit.ptr_byte) begin
            next_st.ptr[st.hit.idx] = ptr_store(st.ptr[st.hit.idx],
              st.hit.ofs == datapath_pkg::OFS_HIGH, res);
          end else if (wr_file && st.hit.status && !flag_op) begin
            next_st.flags = res[4:0];
          end
        end else begin
          next_st.w_wr   = 1'b1;
          next_st.w_data = res;
        end
        // flag updates win over any store into status
        if (flag_op) begin
          next_st.flags = f;
        end
        next_st.done  = 1'b1;
        next_st.state = datapath_pkg::ST_IDLE;
      end
      default: begin
        next_st.state = datapath_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st       <= '0;
      st.state <= datapath_pkg::ST_IDLE;
      st.flags <= datapath_pkg::STATUS_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign req_ready    = st.state[0];
  assign done         = st.done;
  assign w_wr         = st.w_wr;
  assign w_data       = st.w_data;
  assign status_flags = {3'h0, st.flags};
  assign mem          = st.mem;
  assign reg_rdata    = st.rdata;

endmodule

// ---- rtl/datapath_pkg.sv ----
package datapath_pkg;

  // widths
  localparam int ADDR_W  = 12;
  localparam int BYTE_W  = 8;
  localparam int BANK_W  = 4;
  localparam int FLAG_W  = 5;
  localparam int NUM_PTR = 3;

  // status bit positions and value after reset
  localparam int STATUS_NEG_BIT   = 4;
  localparam int STATUS_OVF_BIT   = 3;
  localparam int STATUS_ZERO_BIT  = 2;
  localparam int STATUS_NIB_BIT   = 1;
  localparam int STATUS_CARRY_BIT = 0;
  localparam logic [FLAG_W-1:0] STATUS_RESET = 5'h00;

  // data memory map of the pointer operands and the status register
  localparam logic [ADDR_W-1:0] PTR_PLAIN_BASE = 12'hFEF;
  localparam logic [ADDR_W-1:0] PTR_STRIDE     = 12'h008;
  localparam logic [ADDR_W-1:0] STATUS_ADDR    = 12'hFD8;
  localparam logic [2:0] OFS_PLAIN      = 3'h0;
  localparam logic [2:0] OFS_INC_AFTER  = 3'h1;
  localparam logic [2:0] OFS_DEC_AFTER  = 3'h2;
  localparam logic [2:0] OFS_INC_BEFORE = 3'h3;
  localparam logic [2:0] OFS_OFFSET     = 3'h4;
  localparam logic [2:0] OFS_HIGH       = 3'h5;
  localparam logic [2:0] OFS_LOW        = 3'h6;

  // access bank: low part in bank 0, high part in this bank
  localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [BYTE_W-1:0] ACCESS_SPLIT_DEF = 8'h80;

  // register port indices
  localparam logic [3:0] REG_STATUS   = 4'h0;
  localparam logic [3:0] REG_PTR_BASE = 4'h1;
  localparam logic [3:0] REG_LAST     = 4'h6;

  typedef enum logic [3:0] {
    OP_PASS = 4'h0,
    OP_ADD  = 4'h1,
    OP_SUB  = 4'h2,
    OP_SUBR = 4'h3,
    OP_AND  = 4'h4,
    OP_IOR  = 4'h5,
    OP_XOR  = 4'h6,
    OP_MOVF = 4'h7,
    OP_RRC  = 4'h8,
    OP_RLC  = 4'h9
  } alu_op_e;

  typedef enum logic [1:0] {
    MODE_NONE = 2'h0,
    MODE_FILE = 2'h1,
    MODE_FULL = 2'h2
  } addr_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } state_e;

  typedef struct packed {
    alu_op_e            op;
    addr_mode_e         mode;
    logic               access;
    logic               dest;
    logic               use_lit;
    logic [BYTE_W-1:0]  file_addr;
    logic [ADDR_W-1:0]  full_addr;
    logic [BYTE_W-1:0]  lit;
    logic [BANK_W-1:0]  bank;
    logic [BYTE_W-1:0]  w;
  } req_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              rd;
    logic              wr;
    logic [BYTE_W-1:0] wdata;
  } mem_s;

  typedef struct packed {
    logic       virt;
    logic       ptr_byte;
    logic       status;
    logic [1:0] idx;
    logic [2:0] ofs;
  } sfr_hit_s;

  typedef struct packed {
    state_e                         state;
    logic [FLAG_W-1:0]              flags;
    logic [NUM_PTR-1:0][ADDR_W-1:0] ptr;
    alu_op_e                        op;
    logic                           dest;
    logic                           kill;
    logic                           internal;
    logic                           no_file;
    sfr_hit_s                       hit;
    logic [BYTE_W-1:0]              b;
    logic [BYTE_W-1:0]              w;
    mem_s                           mem;
    logic                           done;
    logic                           w_wr;
    logic [BYTE_W-1:0]              w_data;
    logic [BYTE_W-1:0]              rdata;
  } state_s;

endpackage

// ---- sim/data_mem_model.sv ----
`timescale 1ns/1ps
module data_mem_model (
  // clock
  input  wire logic               clk,
  // memory side of the block
  input  wire datapath_pkg::mem_s mem,
  output logic [7:0]              mem_rdata
);
  logic [7:0] store [0:4095];
  logic       rd_q = 1'b0;
  logic [7:0] last = 8'h00;

  // data stand in the read cycle and the one after, otherwise scrambled
  assign mem_rdata = (mem.rd || rd_q) ? store[mem.addr] : ~last;

  always @(posedge clk) begin
    rd_q <= mem.rd;
    if (mem.rd) begin
      last <= store[mem.addr];
    end
    if (mem.wr) begin
      store[mem.addr] <= mem.wdata;
    end
  end
endmodule

// ---- sim/operand_address_and_flags_checker.sv ----
`timescale 1ns/1ps
module operand_address_and_flags_checker #(
  parameter logic [7:0] ACCESS_SPLIT = datapath_pkg::ACCESS_SPLIT_DEF
) (
  // clock and reset
  input wire logic               clk,
  input wire logic               rst_b,
  // request and results
  input wire logic               req_valid,
  input wire datapath_pkg::req_s req,
  input wire logic               req_ready,
  input wire logic               done,
  input wire logic               w_wr,
  input wire logic [7:0]         w_data,
  input wire logic [7:0]         status_flags,
  input wire datapath_pkg::mem_s mem,
  // register port
  input wire logic [3:0]         reg_addr,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_rdata
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  logic take;
  assign take = req_valid && req_ready;

  handshake_timing_a: assert property (take |=> !req_ready ##1 (req_ready && done))
    else $error("request not finished two cycles after acceptance");
  unused_status_a: assert property (status_flags[7:5] == 3'h0)
    else $error("status upper bits not zero");
  status_readback_a: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata == {3'h0, $past(status_flags[4:0])})
    else $error("status read value wrong");
  high_nibble_a: assert property (reg_rd && reg_addr[0] && reg_addr <= 4'h5 |=> reg_rdata[7:4] == 4'h0)
    else $error("pointer high byte upper bits not zero");
  unmapped_read_a: assert property (reg_rd && reg_addr > 4'h6 |=> reg_rdata == 8'h00)
    else $error("unmapped register read not zero");
  flags_steady_a: assert property (!done && !$past(reg_wr && reg_addr == 4'h0) |-> $stable(status_flags))
    else $error("flags changed without an operation");
  bank_direct_a: assert property (take && req.mode == datapath_pkg::MODE_FILE && req.access && req.bank != 4'hF
    |=> mem.rd && mem.addr == {$past(req.bank), $past(req.file_addr)})
    else $error("banked address wrong");
  access_low_a: assert property (take && req.mode == datapath_pkg::MODE_FILE && !req.access
    && req.file_addr < ACCESS_SPLIT |=> mem.rd && mem.addr == {4'h0, $past(req.file_addr)})
    else $error("access bank address wrong");
  full_addr_a: assert property (take && req.mode == datapath_pkg::MODE_FULL && req.full_addr[11:8] != 4'hF
    |=> mem.rd && mem.addr == $past(req.full_addr))
    else $error("full address wrong");
  dest_select_a: assert property (take && req.mode == datapath_pkg::MODE_FILE && req.access && req.bank != 4'hF
    |-> ##2 (w_wr != $past(req.dest, 2)) && (mem.wr == $past(req.dest, 2)))
    else $error("result sent to wrong destination");
  sign_zero_a: assert property (done && w_wr && $past(take && req.op == datapath_pkg::OP_ADD, 2)
    |-> status_flags[4] == w_data[7] && status_flags[2] == (w_data == 8'h00))
    else $error("negative or zero flag disagrees with result");
endmodule

bind operand_address_and_flags operand_address_and_flags_checker #(.ACCESS_SPLIT(ACCESS_SPLIT)) chk_u (
  .clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req(req), .req_ready(req_ready), .done(done), .w_wr(w_wr),
  .w_data(w_data), .status_flags(status_flags), .mem(mem), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata));

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic               clk;
  logic               rst_b;
  logic               req_valid;
  datapath_pkg::req_s req;
  logic               req_ready;
  logic               done;
  logic               w_wr;
  logic [7:0]         w_data;
  logic [7:0]         status_flags;
  datapath_pkg::mem_s mem;
  logic [7:0]         mem_rdata;
  logic [3:0]         reg_addr;
  logic [7:0]         reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [7:0]         reg_rdata;
  logic [7:0]         res_w;
  logic [7:0]         res_f;
  logic [7:0]         res_d;
  logic [11:0]        res_a;
  logic               res_wr;
  logic               res_m;
  int                 miscompares = 0;
  int                 check_count = 0;
  int                 cycles = 0;

  operand_address_and_flags dut_u (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .done(done), .w_wr(w_wr), .w_data(w_data), .status_flags(status_flags), .mem(mem),
    .mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  data_mem_model mem_u (.clk(clk), .mem(mem), .mem_rdata(mem_rdata));

  task automatic finish_test();
    if (miscompares == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [11:0] e, input logic [11:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic rwr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk($sformatf("register %0h", a), {4'h0, e}, {4'h0, reg_rdata});
    @(posedge clk);
  endtask

  function automatic datapath_pkg::req_s mk(input datapath_pkg::alu_op_e o, input datapath_pkg::addr_mode_e m,
    input logic a, input logic d, input logic [11:0] f, input logic [3:0] b, input logic [7:0] w, input logic [7:0] l);
    mk           = '0;
    mk.op        = o;
    mk.mode      = m;
    mk.access    = a;
    mk.dest      = d;
    mk.use_lit   = (m == datapath_pkg::MODE_NONE);
    mk.file_addr = f[7:0];
    mk.full_addr = f;
    mk.lit       = l;
    mk.bank      = b;
    mk.w         = w;
  endfunction

  // expected {result, N, OV, Z, DC, C}; subtraction adds the complement
  function automatic logic [12:0] alu_exp(input logic [7:0] a, input logic [7:0] b, input logic sub);
    logic [7:0] t;
    logic [8:0] s;
    logic [4:0] h;
    t = sub ? ~b : b;
    s = {1'b0, a} + {1'b0, t} + {8'h00, sub};
    h = {1'b0, a[3:0]} + {1'b0, t[3:0]} + {4'h0, sub};
    return {s[7:0], s[7], (a[7] == t[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
  endfunction

  task automatic op(input datapath_pkg::req_s r);
    int n;
    req       <= r;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (done !== 1'b1 && n < 8);
    {res_w, res_f, res_wr, res_m, res_a, res_d} = {w_data, status_flags, w_wr, mem.wr, mem.addr, mem.wdata};
    chk("done delay", 12'h001, n[11:0]);
    @(posedge clk);
  endtask

  // access bank operand with an unrelated bank value
  task automatic fo(input datapath_pkg::alu_op_e o, input logic [7:0] f, input logic d, input logic [7:0] w);
    op(mk(o, datapath_pkg::MODE_FILE, 1'b0, d, {4'h0, f}, 4'h5, w, 8'h00));
  endtask

  task automatic t_regs();
    for (int i = 0; i < 8; i++) begin
      rchk(4'(i), 8'h00);
    end
    rwr(4'h0, 8'hFF);
    rchk(4'h0, 8'h1F);
    rwr(4'h5, 8'hFF);
    rchk(4'h5, 8'h0F);
    rwr(4'h7, 8'h5A);
    rchk(4'h7, 8'h00);
  endtask

  task automatic t_arith();
    logic [15:0] pr [5] = '{16'h7F01, 16'hFF01, 16'h0808, 16'h0305, 16'h8001};
    logic [12:0] e;
    for (int i = 0; i < 10; i++) begin
      op(mk(i[0] ? datapath_pkg::OP_SUBR : datapath_pkg::OP_ADD, datapath_pkg::MODE_NONE, 1'b0, 1'b0, 12'h000,
        4'h0, pr[i/2][15:8], pr[i/2][7:0]));
      e = i[0] ? alu_exp(pr[i/2][7:0], pr[i/2][15:8], 1'b1) : alu_exp(pr[i/2][15:8], pr[i/2][7:0], 1'b0);
      chk("sum", {4'h0, e[12:5]}, {4'h0, res_w});
      chk("flags", {7'h00, e[4:0]}, {4'h0, res_f});
    end
  endtask

  task automatic t_rot();
    mem_u.store[12'h120] = 8'h88;
    rwr(4'h0, 8'h01);
    op(mk(datapath_pkg::OP_RLC, datapath_pkg::MODE_FILE, 1'b1, 1'b0, 12'h020, 4'h1, 8'h00, 8'h00));
    chk("bank address", 12'h120, res_a);
    chk("left result", 12'h011, {4'h0, res_w});
    chk("left flags", 12'h003, {4'h0, res_f});
    mem_u.store[12'h120] = 8'h01;
    rwr(4'h0, 8'h01);
    op(mk(datapath_pkg::OP_RRC, datapath_pkg::MODE_FILE, 1'b1, 1'b0, 12'h020, 4'h1, 8'h00, 8'h00));
    chk("right result", 12'h080, {4'h0, res_w});
    chk("right flags", 12'h011, {4'h0, res_f});
  endtask

  task automatic t_dir();
    mem_u.store[12'h010] = 8'h04;
    fo(datapath_pkg::OP_ADD, 8'h10, 1'b1, 8'h03);
    chk("access address", 12'h010, res_a);
    chk("written sum", 12'h007, {4'h0, res_d});
    chk("memory write", 12'h001, {11'h000, res_m});
    mem_u.store[12'h345] = 8'h5A;
    op(mk(datapath_pkg::OP_PASS, datapath_pkg::MODE_FULL, 1'b1, 1'b0, 12'h345, 4'h7, 8'h00, 8'h00));
    chk("full address", 12'h345, res_a);
    chk("full data", 12'h05A, {4'h0, res_w});
  endtask

  task automatic t_logic();
    logic [12:0] e;
    mem_u.store[12'h030] = 8'h35;
    e = alu_exp(8'h35, 8'h35, 1'b1);
    fo(datapath_pkg::OP_SUB, 8'h30, 1'b0, 8'h35);
    chk("difference", {4'h0, e[12:5]}, {4'h0, res_w});
    chk("difference flags", {7'h00, e[4:0]}, {4'h0, res_f});
    fo(datapath_pkg::OP_AND, 8'h30, 1'b0, 8'hF0);
    chk("and result", 12'h030, {4'h0, res_w});
    chk("and flags", 12'h003, {4'h0, res_f});
    fo(datapath_pkg::OP_IOR, 8'h30, 1'b0, 8'h80);
    chk("or result", 12'h0B5, {4'h0, res_w});
    chk("or flags", 12'h013, {4'h0, res_f});
    fo(datapath_pkg::OP_XOR, 8'h30, 1'b0, 8'h35);
    chk("xor result", 12'h000, {4'h0, res_w});
    chk("xor flags", 12'h007, {4'h0, res_f});
    fo(datapath_pkg::OP_MOVF, 8'h30, 1'b0, 8'h00);
    chk("move result", 12'h035, {4'h0, res_w});
    chk("move flags", 12'h003, {4'h0, res_f});
  endtask

  task automatic t_ptr();
    mem_u.store[12'h1FF] = 8'hA1;
    mem_u.store[12'h200] = 8'hA2;
    mem_u.store[12'h201] = 8'hA3;
    rwr(4'h1, 8'h01);
    rwr(4'h2, 8'hFF);
    rwr(4'h0, 8'h1F);
    fo(datapath_pkg::OP_PASS, 8'hEE, 1'b0, 8'h00);
    chk("inc after data", 12'h0A1, {4'h0, res_w});
    chk("flags after step", 12'h01F, {4'h0, res_f});
    rchk(4'h1, 8'h02);
    rchk(4'h2, 8'h00);
    fo(datapath_pkg::OP_PASS, 8'hEC, 1'b0, 8'h00);
    chk("inc before data", 12'h0A3, {4'h0, res_w});
    fo(datapath_pkg::OP_PASS, 8'hED, 1'b0, 8'h00);
    chk("dec after data", 12'h0A3, {4'h0, res_w});
    fo(datapath_pkg::OP_PASS, 8'hEF, 1'b0, 8'h00);
    chk("plain data", 12'h0A2, {4'h0, res_w});
    fo(datapath_pkg::OP_ADD, 8'hEB, 1'b1, 8'hFF);
    chk("offset address", 12'h1FF, res_a);
    chk("offset sum", 12'h0A0, {4'h0, res_d});
    chk("offset accumulator", 12'h000, {11'h000, res_wr});
    rchk(4'h2, 8'h00);
  endtask

  task automatic t_virt();
    rwr(4'h1, 8'h0F);
    rwr(4'h2, 8'hE7);
    fo(datapath_pkg::OP_PASS, 8'hEF, 1'b0, 8'h55);
    chk("virtual read", 12'h000, {4'h0, res_w});
    fo(datapath_pkg::OP_ADD, 8'hEF, 1'b1, 8'h55);
    chk("virtual write", 12'h000, {11'h000, res_m});
    rchk(4'h4, 8'h00);
    rwr(4'h2, 8'hE9);
    fo(datapath_pkg::OP_ADD, 8'hEE, 1'b1, 8'h01);
    rchk(4'h2, 8'hEA);
    rchk(4'h1, 8'h0F);
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    rst_b     = 1'b0;
    req_valid = 1'b0;
    req       = '0;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_arith();
    t_rot();
    t_dir();
    t_logic();
    t_ptr();
    t_virt();
    finish_test();
  end

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end
endmodule
